// file: design/cfc_pkg.sv
// Package for the CAN FIFO channel control block: register map, field layout, types.
// Assumes an AXI4-Lite master on the register side and a protocol engine on the far side.
// Operation
// - Depth code n gives n+1 message slots, 1 to 16; codes 10000 and above are reserved.
// - Writing one to the clear request resets the FIFO and hardware drops the bit when done.
// - In a transmit FIFO the pointer advance bit moves the head on by one slot.
// - In a receive FIFO the pointer advance bit moves the tail on by one slot.
// - A receive FIFO stores only data bytes when payload-only is set, else whole messages.
// - Depth and payload-only take writes only while the operating mode is configuration.
// - The aborted flag is refreshed when a message completes or aborts and on FIFO reset.
// - Arbitration-lost and transmit-error flags clear on any control read and on FIFO reset.
// - Unimplemented control bits read as zero and ignore writes.
// - Direction select one makes a transmit FIFO, zero a receive FIFO.
// - Send request starts sending, clears when all is sent, and a software clear aborts.
// - With auto remote reply enabled a received remote request sets the send request.
// - The two-bit priority ranks the FIFO, 11 highest down to 00 lowest.
package cfc_pkg;
    localparam logic [3:0] CFC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] CFC_ADDR_STAT = 4'h4;
    localparam logic [3:0] CFC_ADDR_CLR = 4'h8;
    localparam logic [3:0] CFC_ADDR_IEN = 4'hC;
    localparam int CFC_DEPTH_LSB = 16;
    localparam int CFC_CLEAR_BIT = 14;
    localparam int CFC_ADV_BIT = 13;
    localparam int CFC_PONLY_BIT = 12;
    localparam int CFC_DIR_BIT = 7;
    localparam int CFC_ABORT_BIT = 6;
    localparam int CFC_ARB_BIT = 5;
    localparam int CFC_TERR_BIT = 4;
    localparam int CFC_SEND_BIT = 3;
    localparam int CFC_RTR_BIT = 2;
    localparam int CFC_IRQ_W = 4;
    localparam logic [2:0] CFC_MODE_CONFIG = 3'h4;
    localparam logic [4:0] CFC_DEPTH_MAX = 5'h0F;
    localparam logic [31:0] CFC_CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] CFC_RESP_OKAY = 2'h0;
    localparam logic [1:0] CFC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic done_ok;
        logic aborted;
        logic arb_lost;
        logic bus_error;
        logic rtr_rx;
        logic rx_push;
        logic tx_pop;
    } cfc_engine_evt_t;

    typedef struct packed {
        logic tx_mode;
        logic send_request;
        logic [1:0] priority_rank;
        logic payload_only;
        logic [3:0] head;
        logic [3:0] tail;
        logic [4:0] count;
        logic full;
        logic empty;
    } cfc_engine_view_t;
endpackage

// file: design/cfc_channel.sv
// One FIFO channel control with AXI4-Lite register slave and interrupt.
// Assumes one clock; engine events are synchronous one-cycle pulses.
`timescale 1ns/1ps
module cfc_channel (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Main controller mode and engine side
    input wire logic [2:0] operating_mode_field_in,
    input wire cfc_pkg::cfc_engine_evt_t engine_evt_in,
    output cfc_pkg::cfc_engine_view_t engine_view_out,
    // Interrupt
    output logic irq_out
);
    import cfc_pkg::*;

    default clocking cfc_cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic [4:0] depth_q;
    logic clear_q, adv_q, ponly_q, dir_q, abort_q, arb_q, terr_q, send_q, rtr_q;
    logic [1:0] prio_q;
    logic [3:0] head_q, tail_q;
    logic [4:0] count_q;
    logic [3:0] ist_q, ien_q;
    logic aw_q, w_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic bvalid_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] bresp_q, rresp_q;

    function automatic logic [3:0] cfc_wrap(input logic [3:0] p, input logic [4:0] d);
        cfc_wrap = (p == d[3:0]) ? 4'h0 : p + 4'h1;
    endfunction

    // Capacity code: reserved codes saturate at 16 slots
    logic [4:0] last_slot;
    assign last_slot = (depth_q > CFC_DEPTH_MAX) ? CFC_DEPTH_MAX : depth_q;
    logic full, empty;
    assign full = (count_q == last_slot + 5'h01);
    assign empty = (count_q == 5'h00);

    // Write channel: address and data taken in either order
    logic wr_fire, rd_fire, ctrl_rd;
    assign s_axi_awready_out = !aw_q && !bvalid_q;
    assign s_axi_wready_out = !w_q && !bvalid_q;
    assign wr_fire = aw_q && w_q && !bvalid_q;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_q <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata_in;
            end else if (wr_fire) begin
                w_q <= 1'b0;
            end
        end
    end
    // Byte strobes ignored; registers are whole-word
    logic unused_strb;
    assign unused_strb = ^s_axi_wstrb_in;

    logic wr_ctrl, wr_clr, wr_ien, wr_ok;
    assign wr_ctrl = wr_fire && awaddr_q == CFC_ADDR_CTRL;
    assign wr_clr = wr_fire && awaddr_q == CFC_ADDR_CLR;
    assign wr_ien = wr_fire && awaddr_q == CFC_ADDR_IEN;
    assign wr_ok = (awaddr_q == CFC_ADDR_CTRL) || (awaddr_q == CFC_ADDR_CLR)
        || (awaddr_q == CFC_ADDR_IEN) || (awaddr_q == CFC_ADDR_STAT);
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= CFC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? CFC_RESP_OKAY : CFC_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;

    // Read channel: one cycle to data
    assign s_axi_arready_out = !rvalid_q;
    assign rd_fire = s_axi_arvalid_in && !rvalid_q;
    assign ctrl_rd = rd_fire && s_axi_araddr_in == CFC_ADDR_CTRL;
    logic [31:0] ctrl_word;
    always_comb begin
        ctrl_word = CFC_CTRL_RESET;
        ctrl_word[CFC_DEPTH_LSB +: 5] = depth_q;
        ctrl_word[CFC_CLEAR_BIT] = clear_q;
        ctrl_word[CFC_ADV_BIT] = adv_q;
        ctrl_word[CFC_PONLY_BIT] = ponly_q;
        ctrl_word[CFC_DIR_BIT] = dir_q;
        ctrl_word[CFC_ABORT_BIT] = abort_q;
        ctrl_word[CFC_ARB_BIT] = arb_q;
        ctrl_word[CFC_TERR_BIT] = terr_q;
        ctrl_word[CFC_SEND_BIT] = send_q;
        ctrl_word[CFC_RTR_BIT] = rtr_q;
        ctrl_word[1:0] = prio_q;
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= CFC_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= CFC_RESP_OKAY;
            unique case (s_axi_araddr_in)
                CFC_ADDR_CTRL: rdata_q <= ctrl_word;
                CFC_ADDR_STAT: rdata_q <= {28'h0000000, ist_q};
                CFC_ADDR_IEN: rdata_q <= {28'h0000000, ien_q};
                CFC_ADDR_CLR: rdata_q <= 32'h0000_0000;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= CFC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;

    // Depth and payload-only locked outside configuration mode; direction, remote reply and priority always writable
    logic cfg_mode;
    assign cfg_mode = operating_mode_field_in == CFC_MODE_CONFIG;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            depth_q <= 5'h00;
            ponly_q <= 1'b0;
        end else if (wr_ctrl && cfg_mode) begin
            depth_q <= wdata_q[CFC_DEPTH_LSB +: 5];
            ponly_q <= wdata_q[CFC_PONLY_BIT];
        end
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dir_q <= 1'b0;
            rtr_q <= 1'b0;
            prio_q <= 2'h0;
        end else if (wr_ctrl) begin
            dir_q <= wdata_q[CFC_DIR_BIT];
            rtr_q <= wdata_q[CFC_RTR_BIT];
            prio_q <= wdata_q[1:0];
        end
    end

    // Clear request: one-cycle reset step then hardware drops the bit
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            clear_q <= 1'b0;
        end else if (wr_ctrl && wdata_q[CFC_CLEAR_BIT]) begin
            clear_q <= 1'b1;
        end else if (clear_q) begin
            clear_q <= 1'b0;
        end
    end

    // Pointer advance: software sets, hardware steps once and clears
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            adv_q <= 1'b0;
        end else if (wr_ctrl && wdata_q[CFC_ADV_BIT]) begin
            adv_q <= 1'b1;
        end else begin
            adv_q <= 1'b0;
        end
    end

    // Head is the software fill side of a transmit FIFO, tail the drain of a receive FIFO
    logic head_step, tail_step, in_step, out_step;
    assign head_step = (adv_q && dir_q) || (engine_evt_in.rx_push && !dir_q);
    assign tail_step = (adv_q && !dir_q) || (engine_evt_in.tx_pop && dir_q);
    assign in_step = head_step && !full;
    assign out_step = tail_step && !empty;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            head_q <= 4'h0;
            tail_q <= 4'h0;
            count_q <= 5'h00;
        end else if (clear_q) begin
            head_q <= 4'h0;
            tail_q <= 4'h0;
            count_q <= 5'h00;
        end else begin
            if (in_step) head_q <= cfc_wrap(head_q, last_slot);
            if (out_step) tail_q <= cfc_wrap(tail_q, last_slot);
            count_q <= count_q + {4'h0, in_step} - {4'h0, out_step};
        end
    end

    // Send request: set by software or remote request, cleared when drained
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            send_q <= 1'b0;
        end else if (clear_q || !dir_q) begin
            send_q <= 1'b0;
        end else if (wr_ctrl) begin
            send_q <= wdata_q[CFC_SEND_BIT];
        end else if (rtr_q && engine_evt_in.rtr_rx) begin
            send_q <= 1'b1;
        end else if (engine_evt_in.tx_pop && count_q == 5'h01) begin
            send_q <= 1'b0;
        end
    end

    // Transmit status flags; a completion event wins over a reset in the same cycle
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            abort_q <= 1'b0;
        end else if (engine_evt_in.done_ok || engine_evt_in.aborted) begin
            abort_q <= engine_evt_in.aborted;
        end else if (clear_q) begin
            abort_q <= 1'b0;
        end
    end
    // Event set wins over a read clear in the same cycle
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            arb_q <= 1'b0;
            terr_q <= 1'b0;
        end else begin
            arb_q <= engine_evt_in.arb_lost || (arb_q && !ctrl_rd && !clear_q);
            terr_q <= engine_evt_in.bus_error || (terr_q && !ctrl_rd && !clear_q);
        end
    end

    // Interrupt status: done, aborted, arbitration lost, bus error
    logic [3:0] ev;
    assign ev = {engine_evt_in.bus_error, engine_evt_in.arb_lost,
        engine_evt_in.aborted, engine_evt_in.done_ok};
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ist_q <= 4'h0;
            ien_q <= 4'h0;
        end else begin
            ist_q <= ev | (ist_q & ~(wr_clr ? wdata_q[3:0] : 4'h0));
            if (wr_ien) ien_q <= wdata_q[3:0];
        end
    end
    assign irq_out = |(ist_q & ien_q);

    always_comb begin
        engine_view_out.tx_mode = dir_q;
        engine_view_out.send_request = send_q;
        engine_view_out.priority_rank = prio_q;
        engine_view_out.payload_only = ponly_q && !dir_q;
        engine_view_out.head = head_q;
        engine_view_out.tail = tail_q;
        engine_view_out.count = count_q;
        engine_view_out.full = full;
        engine_view_out.empty = empty;
    end

    // Clear takes one cycle; the next shows an empty FIFO with the bit dropped
    sequence cfc_seq_cleared;
        !clear_q && count_q == 5'h00 && head_q == 4'h0 && tail_q == 4'h0;
    endsequence
    // Advance standing with no new write racing the hardware drop
    sequence cfc_seq_adv_only;
        adv_q && !wr_ctrl;
    endsequence
    AST_CLEAR_DONE: assert property (clear_q |=> cfc_seq_cleared)
        else $error("clear request not completed");
    AST_CFG_LOCK: assert property (!(wr_ctrl && cfg_mode)
        |=> $stable(depth_q) && $stable(ponly_q))
        else $error("config field changed outside config mode");
    // A one-slot FIFO wraps onto itself, so its pointer cannot move
    AST_HEAD_STEP: assert property (adv_q && dir_q && !full && !clear_q
        && last_slot != 5'h00 |=> head_q != $past(head_q))
        else $error("head did not advance");
    AST_TAIL_STEP: assert property (adv_q && !dir_q && !empty && !clear_q
        && last_slot != 5'h00 |=> tail_q != $past(tail_q))
        else $error("tail did not advance");
    AST_READ_CLEARS: assert property (ctrl_rd && !engine_evt_in.arb_lost
        |=> !arb_q)
        else $error("arbitration flag survived read");
    AST_RESERVED_ZERO: assert property (ctrl_word[31:21] == 11'h000
        && ctrl_word[15] == 1'b0 && ctrl_word[11:8] == 4'h0)
        else $error("reserved bits nonzero");
    AST_ABORT_UPD: assert property (engine_evt_in.aborted |=> abort_q)
        else $error("abort flag not set");
    AST_RTR_SET: assert property (dir_q && rtr_q && engine_evt_in.rtr_rx
        && !wr_ctrl && !clear_q |=> send_q)
        else $error("remote request did not set send");
    AST_ADV_PULSE: assert property (cfc_seq_adv_only |=> !adv_q)
        else $error("pointer advance did not self clear");
    AST_SEND_DRAIN: assert property (dir_q && engine_evt_in.tx_pop
        && count_q == 5'h01 && !wr_ctrl && !(rtr_q && engine_evt_in.rtr_rx) |=> !send_q)
        else $error("send request not dropped after last message");
endmodule

// file: verif/cfc_engine_model.sv
// Protocol engine stand-in: one-cycle event pulses towards the channel.
// Assumes the bench calls fire() just after a rising edge of the core clock.
`timescale 1ns/1ps
module cfc_engine_model
    import cfc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Events towards the channel
    output cfc_pkg::cfc_engine_evt_t engine_evt_out
);
    initial begin
        engine_evt_out = '0;
    end
    // A long gap models a slow engine; pulses never touch, so each lands alone
    task automatic fire(input cfc_engine_evt_t ev, input int gap);
        repeat (gap + 1) @(posedge core_clk_in);
        engine_evt_out <= ev;
        @(posedge core_clk_in);
        engine_evt_out <= '0;
    endtask
endmodule

// file: verif/tb_can_fifo_channel_control.sv
// Self-checking bench for the FIFO channel control over AXI4-Lite.
// Assumes the engine model beside it supplies all engine events.
`timescale 1ns/1ps
module tb_can_fifo_channel_control;
    import cfc_pkg::*;
    localparam int EV_DONE = 6, EV_ABORT = 5, EV_ARB = 4, EV_TERR = 3;
    localparam int EV_RTR = 2, EV_PUSH = 1, EV_POP = 0;
    logic core_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [2:0] mode = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    cfc_engine_evt_t evt;
    cfc_engine_view_t view;
    int err_total = 0;
    int num_checks = 0;

    cfc_channel DUT (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .operating_mode_field_in(mode), .engine_evt_in(evt), .engine_view_out(view),
        .irq_out(irq));
    cfc_engine_model eng (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .engine_evt_out(evt));

    always #20 core_clk_in = ~core_clk_in;

    task automatic summarize();
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang(input string what);
        err_total++;
        $display("Error %s expected answer seen none", what);
        summarize();
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    function automatic cfc_engine_evt_t ev(input int k);
        ev = '0;
        ev[k] = 1'b1;
    endfunction
    // Address and data go out together; each is dropped at its own taking edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) hang("write response");
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        int n;
        @(posedge core_clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk_in);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) hang("read data");
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task automatic poll_clear();
        int n;
        for (n = 0; n < 20; n++) begin
            rd_reg(CFC_ADDR_CTRL);
            if (rd[CFC_CLEAR_BIT] === 1'b0) break;
        end
        if (n == 20) hang("clear request drop");
        chk("clear request", 32'h0, {31'h0, rd[CFC_CLEAR_BIT]});
    endtask

    task automatic t_reset();
        rd_reg(CFC_ADDR_CTRL);
        chk("ctrl read resp", {30'h0, CFC_RESP_OKAY}, {30'h0, rsp});
        chk("ctrl at reset", CFC_CTRL_RESET, rd);
        chk("empty at reset", 32'h1, {31'h0, view.empty});
        rd_reg(4'h2);
        chk("unmapped resp", {30'h0, CFC_RESP_SLVERR}, {30'h0, rsp});
        wr(4'h2, 32'hFFFF_FFFF);
        chk("unmapped write resp", {30'h0, CFC_RESP_SLVERR}, {30'h0, rsp});
        $display("Test reset done");
    endtask
    // Outside configuration all bits but clear and advance are written as one, but depth and payload-only hold
    task automatic t_lock();
        mode <= 3'h0;
        wr(CFC_ADDR_CTRL, 32'hFFFF_9FFF);
        chk("ctrl write resp", {30'h0, CFC_RESP_OKAY}, {30'h0, rsp});
        settle(1);
        rd_reg(CFC_ADDR_CTRL);
        chk("ctrl locked", 32'h0000_0087, rd & ~32'h0000_0008);
        chk("priority", 32'h3, {30'h0, view.priority_rank});
        chk("tx mode", 32'h1, {31'h0, view.tx_mode});
        mode <= CFC_MODE_CONFIG;
        wr(CFC_ADDR_CTRL, 32'h0003_1000);
        settle(1);
        rd_reg(CFC_ADDR_CTRL);
        chk("ctrl config", 32'h0003_1000, rd);
        chk("payload only", 32'h1, {31'h0, view.payload_only});
        chk("rx mode", 32'h0, {31'h0, view.tx_mode});
        $display("Test lock done");
    endtask
    // Push 17 messages at both ends of the depth range, overfilling the 16-slot code by one
    task automatic t_depth();
        logic [4:0] codes [2] = '{5'h00, 5'h0F};
        foreach (codes[i]) begin
            wr(CFC_ADDR_CTRL, {11'h0, codes[i], 16'h4000});
            poll_clear();
            repeat (17) eng.fire(ev(EV_PUSH), 0);
            settle(1);
            chk("count full", {27'h0, codes[i]} + 32'h1, {27'h0, view.count});
            chk("full flag", 32'h1, {31'h0, view.full});
        end
        wr(CFC_ADDR_CTRL, 32'h000F_2000);
        settle(2);
        chk("tail step", 32'h1, {28'h0, view.tail});
        chk("count step", 32'hF, {27'h0, view.count});
        rd_reg(CFC_ADDR_CTRL);
        chk("advance self clear", 32'h0, {31'h0, rd[CFC_ADV_BIT]});
        wr(CFC_ADDR_CTRL, 32'h000F_4000);
        poll_clear();
        chk("pointers", 32'h1, {18'h0, view.head, view.tail, view.count, view.empty});
        $display("Test depth done");
    endtask
    task automatic t_tx();
        wr(CFC_ADDR_CTRL, 32'h0003_2080);
        settle(2);
        chk("head step", 32'h1, {28'h0, view.head});
        wr(CFC_ADDR_CTRL, 32'h0003_0088);
        settle(1);
        chk("send set", 32'h1, {31'h0, view.send_request});
        eng.fire(ev(EV_POP), 3);
        settle(1);
        chk("send done", 32'h0, {31'h0, view.send_request});
        eng.fire(ev(EV_ARB), 0);
        eng.fire(ev(EV_TERR), 0);
        settle(1);
        rd_reg(CFC_ADDR_CTRL);
        chk("flags set", 32'h30, rd & 32'h30);
        rd_reg(CFC_ADDR_CTRL);
        chk("flags read clear", 32'h0, rd & 32'h30);
        eng.fire(ev(EV_ABORT), 0);
        rd_reg(CFC_ADDR_CTRL);
        chk("aborted", 32'h40, rd & 32'h40);
        eng.fire(ev(EV_DONE), 0);
        rd_reg(CFC_ADDR_CTRL);
        chk("completed", 32'h0, rd & 32'h40);
        wr(CFC_ADDR_CTRL, 32'h0003_0084);
        eng.fire(ev(EV_RTR), 0);
        settle(1);
        chk("remote reply", 32'h1, {31'h0, view.send_request});
        wr(CFC_ADDR_CTRL, 32'h0003_0080);
        eng.fire(ev(EV_RTR), 0);
        settle(1);
        chk("remote ignored", 32'h0, {31'h0, view.send_request});
        $display("Test transmit done");
    endtask
    task automatic t_irq();
        wr(CFC_ADDR_CLR, 32'h0000_000F);
        wr(CFC_ADDR_IEN, 32'h0000_0002);
        rd_reg(CFC_ADDR_IEN);
        chk("enable readback", 32'h2, rd);
        rd_reg(CFC_ADDR_CLR);
        chk("clear reads zero", 32'h0, rd);
        settle(1);
        chk("irq idle", 32'h0, {31'h0, irq});
        eng.fire(ev(EV_ABORT), 0);
        settle(1);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd_reg(CFC_ADDR_STAT);
        chk("status aborted", 32'h2, rd & 32'h2);
        wr(CFC_ADDR_IEN, 32'h0);
        settle(1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(CFC_ADDR_IEN, 32'h0000_0002);
        settle(1);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(CFC_ADDR_CLR, 32'h0000_0002);
        settle(1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd_reg(CFC_ADDR_STAT);
        chk("status cleared", 32'h0, rd & 32'h2);
        $display("Test interrupt done");
    endtask

    initial begin
        repeat (2) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        settle(1);
        t_reset();
        t_lock();
        t_depth();
        t_tx();
        t_irq();
        summarize();
    end
endmodule
